// file: rtl/rtcs_defs.vh
// constants of the clock status and system-data block
`ifndef RTCS_DEFS_VH
`define RTCS_DEFS_VH
`define RTCS_IX_AREA_DESC 16'hea10
`define RTCS_IX_AREA_STAT 16'hea12
`define RTCS_IX_STAT_LOC 16'hea14
`define RTCS_IX_HW_STAT 16'hea16
`define RTCS_IX_CORR 16'hea18
`define RTCS_IX_STATUS 16'hea1a
`define RTCS_IX_DATA 16'hea20
`define RTCS_IX_DATA_END 16'hea36
`define RTCS_ST_CLK_ERR 0
`define RTCS_ST_MODE12 1
`define RTCS_ST_CLK_REQ 2
`define RTCS_ST_READABLE 3
`define RTCS_ST_STOP_UPD 4
`define RTCS_ST_CAPTURE 5
`define RTCS_ST_OH_ERR 8
`define RTCS_ST_OH_EN 9
`define RTCS_ST_OH_REQ 10
`define RTCS_ST_PR_ERR 12
`define RTCS_ST_PR_HIT 13
`define RTCS_ST_PR_REQ 14
`define RTCS_ST_SW_MASK 16'h4636
`define RTCS_ST_RSVD 16'h88c0
`define RTCS_ST_RESET 16'h0000
`define RTCS_HW_CORR_BAD 15
`define RTCS_CORR_LIMIT 16'sd400
`define RTCS_CORR_RESET 16'h0000
`define RTCS_DESC_RESET 16'h0000
`define RTCS_W_CLK_SET 5'd4
`define RTCS_W_PR_SET 5'd8
`define RTCS_W_OH_SET 5'd15
`define RTCS_W_TIME_LAST 5'd3
`define RTCS_W_OH_FIRST 5'd12
`define RTCS_W_OH_LAST 5'd14
`define RTCS_W_SNAP 5'd18
`define RTCS_W_LAST 5'd21
`define RTCS_KEEP 8'hff
`define RTCS_PM_BIT 8'h80
`define RTCS_INIT_YEAR 7'd92
`define RTCS_INIT_MONTH 4'd4
`define RTCS_INIT_DAY 5'd1
`define RTCS_INIT_HOUR 5'd12
`define RTCS_INIT_MIN 6'd0
`define RTCS_INIT_SEC 6'd0
`define RTCS_INIT_WDAY 3'd4
`define RTCS_CLK_NS 50
`define RTCS_SEC_NS 1000000000
`endif

// file: rtl/rtcs_mem.v
// clock data area storage: one write port, one registered read port
`timescale 1ns/1ns
`default_nettype none
module rtcs_mem (
  input wire clk, // clock
  input wire we, // write strobe
  input wire [4:0] wa, // write word index
  input wire [15:0] wd, // write data
  input wire [4:0] ra, // read word index
  output reg [15:0] rd // read data, one cycle after ra
);
  reg [15:0] mem_r [0:31];

  always @(posedge clk) begin
    if (we)
      mem_r[wa] <= wd;
    rd <= mem_r[ra];
  end
endmodule // rtcs_mem
`default_nettype wire

// file: rtl/rtcs_top.v
// clock status word, system-data registers and clock data area engine
`timescale 1ns/1ns
`default_nettype none
`include "rtcs_defs.vh"
module rtcs_top #(
  parameter integer SEC_CYCLES = `RTCS_SEC_NS / `RTCS_CLK_NS
) (
  input wire pclk, // bus clock, 20 MHz
  input wire presetn, // asynchronous reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction, 1 = write
  input wire [19:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error, unmapped address
  input wire run_mode, // 1 = RUN, 0 = STOP
  input wire power_off, // supply down
  input wire battery_ok, // backup battery fitted
  input wire [1:0] chip_fault, // defect flags of the clock chip
  input wire cycle_start, // pulse at start of a program cycle
  output reg prompt_hit, // prompt-reached flag
  output reg clock_readable // clock-readable flag
);
  localparam S_IDLE = 2'd0;
  localparam S_READ = 2'd1;
  localparam S_EVAL = 2'd2;
  localparam K_CLK = 2'd0;
  localparam K_OH = 2'd1;
  localparam K_PR = 2'd2;

  function [7:0] n2b;
    input [6:0] n;
    reg [6:0] t;
    reg [6:0] u;
    begin
      t = n / 7'd10;
      u = n % 7'd10;
      n2b = {t[3:0], u[3:0]};
    end
  endfunction

  function [6:0] b2n;
    input [7:0] b;
    begin
      b2n = {3'b000, b[7:4]} * 7'd10 + {3'b000, b[3:0]};
    end
  endfunction

  function inr;
    input [7:0] b;
    input [6:0] lo;
    input [6:0] hi;
    begin
      inr = (b == `RTCS_KEEP) || (b[7:4] <= 4'd9 && b[3:0] <= 4'd9 &&
        b2n(b) >= lo && b2n(b) <= hi);
    end
  endfunction

  function hr_ok;
    input [7:0] b;
    input m12;
    begin
      if (b == `RTCS_KEEP)
        hr_ok = 1'b1;
      else if (m12)
        hr_ok = inr({1'b0, b[6:0]}, 7'd1, 7'd12);
      else
        hr_ok = !b[7] && inr(b, 7'd0, 7'd23);
    end
  endfunction

  // AM 12 is noon, PM 12 is midnight
  function [4:0] hr24;
    input [7:0] b;
    input m12;
    reg [6:0] h;
    begin
      h = b2n({1'b0, b[6:0]});
      if (m12 && b[7])
        hr24 = (h == 7'd12) ? 5'd0 : h[4:0] + 5'd12;
      else
        hr24 = h[4:0];
    end
  endfunction

  function [7:0] hr_out;
    input [4:0] h;
    input m12;
    begin
      if (!m12 || (h != 5'd0 && h <= 5'd12))
        hr_out = n2b({2'b00, h});
      else if (h == 5'd0)
        hr_out = n2b(7'd12) | `RTCS_PM_BIT;
      else
        hr_out = n2b({2'b00, h - 5'd12}) | `RTCS_PM_BIT;
    end
  endfunction

  function [4:0] mdays;
    input [3:0] m;
    input [6:0] y;
    begin
      case (m)
        4'd2: mdays = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
        4'd4, 4'd6, 4'd9, 4'd11: mdays = 5'd30;
        default: mdays = 5'd31;
      endcase
    end
  endfunction

  function [7:0] bcd_inc;
    input [7:0] b;
    begin
      if (b == 8'h99)
        bcd_inc = 8'h00;
      else if (b[3:0] == 4'd9)
        bcd_inc = {b[7:4] + 4'd1, 4'd0};
      else
        bcd_inc = {b[7:4], b[3:0] + 4'd1};
    end
  endfunction

  reg [15:0] stat_r, stat_nxt, desc0_r, desc1_r, desc2_r, corr_r, rd_val;
  reg [1:0] fault_r, st_r, kind_r;
  reg [5:0] sec_r, min_r, oh_sec_r, oh_min_r;
  reg [4:0] hr_r, day_r, wr_idx_r;
  reg [3:0] mon_r;
  reg [6:0] yr_r;
  reg [2:0] wd_r, iss_r, cap_r;
  reg [7:0] oh_h0_r, oh_h1_r, oh_h2_r;
  reg [7:0] pw_r, pd_r, pm_r, py_r, ph_r, pn_r, ps_r;
  reg [31:0] pre_cnt_r, ref_cnt_r;
  reg [63:0] snap_r;
  reg [15:0] sbuf_r [0:3];
  reg [15:0] wr_val;
  reg pend_r, run_d_r, pwr_d_r, pr_arm_r, tick_d_r;
  reg wr_act_r, upd_t_r, upd_h_r, upd_c_r;
  wire [15:0] mem_q;

  wire [15:0] ix = paddr[17:2];
  wire [15:0] dix = ix - `RTCS_IX_DATA;
  wire hi0 = (paddr[19:18] == 2'b00);
  wire in_data = hi0 && ix >= `RTCS_IX_DATA && ix < `RTCS_IX_DATA_END;
  wire hit_ad = hi0 && ix == `RTCS_IX_AREA_DESC;
  wire hit_as = hi0 && ix == `RTCS_IX_AREA_STAT;
  wire hit_sl = hi0 && ix == `RTCS_IX_STAT_LOC;
  wire hit_hw = hi0 && ix == `RTCS_IX_HW_STAT;
  wire hit_co = hi0 && ix == `RTCS_IX_CORR;
  wire hit_st = hi0 && ix == `RTCS_IX_STATUS;
  wire mapped = in_data | hit_ad | hit_as | hit_sl | hit_hw | hit_co | hit_st;
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pready && pwrite && mapped;
  wire apb_mwr = apb_wr && in_data;
  wire sw_st = apb_wr && hit_st;
  wire mode12 = stat_r[`RTCS_ST_MODE12];

  wire corr_bad = ($signed(corr_r) > `RTCS_CORR_LIMIT) ||
    ($signed(corr_r) < -`RTCS_CORR_LIMIT);
  wire [31:0] per_m1 = SEC_CYCLES - 1 + (corr_bad ? 32'h0 : {{16{corr_r[15]}}, corr_r});
  wire tick = (pre_cnt_r >= per_m1);
  wire ref_exp = (ref_cnt_r >= SEC_CYCLES - 1);
  wire run_fall = run_d_r && !run_mode;
  wire pwr_rise = power_off && !pwr_d_r;
  wire cold = pwr_d_r && !power_off && !battery_ok;

  wire [7:0] bw = sbuf_r[0][7:0];
  wire [7:0] bd = sbuf_r[1][15:8];
  wire [7:0] bm = sbuf_r[1][7:0];
  wire [7:0] by = sbuf_r[2][15:8];
  wire [7:0] bh = sbuf_r[2][7:0];
  wire [7:0] bn = sbuf_r[3][15:8];
  wire [7:0] bs = sbuf_r[3][7:0];
  wire [6:0] nw = b2n(bw);
  wire [6:0] nd = b2n(bd);
  wire [6:0] nn = b2n(bn);
  wire [6:0] ns = b2n(bs);
  wire time_ok = inr(bw, 7'd1, 7'd7) && inr(bd, 7'd1, 7'd31) && inr(bm, 7'd1, 7'd12) &&
    inr(by, 7'd0, 7'd99) && hr_ok(bh, mode12) && inr(bn, 7'd0, 7'd59) &&
    inr(bs, 7'd0, 7'd59);
  wire oh_ok = inr(bw, 7'd0, 7'd59) && inr(bd, 7'd0, 7'd59) && inr(bm, 7'd0, 7'd99) &&
    inr(by, 7'd0, 7'd99) && inr(bh, 7'd0, 7'd99);
  wire ev_done = (st_r == S_EVAL);
  wire ev_ok = (kind_r == K_OH) ? oh_ok : time_ok;
  wire set_clk = ev_done && ev_ok && kind_r == K_CLK;
  wire set_oh = ev_done && ev_ok && kind_r == K_OH;
  wire set_pr = ev_done && ev_ok && kind_r == K_PR;

  // transfers only where the settings may legally be written
  wire xfer_ok = (run_mode || stat_r[`RTCS_ST_STOP_UPD]) && fault_r == 2'b00 &&
    !power_off;
  wire any_req = stat_r[`RTCS_ST_CLK_REQ] | stat_r[`RTCS_ST_OH_REQ] |
    stat_r[`RTCS_ST_PR_REQ];
  wire seq_go = (st_r == S_READ) && !apb_setup && iss_r != 3'd4;
  wire [4:0] seq_base = (kind_r == K_OH) ? `RTCS_W_OH_SET :
    (kind_r == K_PR) ? `RTCS_W_PR_SET : `RTCS_W_CLK_SET;
  wire [4:0] m_ra = apb_setup ? dix[4:0] : seq_base + {3'b000, iss_r[1:0]};

  wire [15:0] tw0 = {8'h00, n2b({4'b0000, wd_r})};
  wire [15:0] tw1 = {n2b({2'b00, day_r}), n2b({3'b000, mon_r})};
  wire [15:0] tw2 = {n2b(yr_r), hr_out(hr_r, mode12)};
  wire [15:0] tw3 = {n2b({1'b0, min_r}), n2b({1'b0, sec_r})};
  wire pr_match = pr_arm_r && (pw_r == `RTCS_KEEP || pw_r == {5'b00000, wd_r}) &&
    (pd_r == `RTCS_KEEP || pd_r == {3'b000, day_r}) &&
    (pm_r == `RTCS_KEEP || pm_r == {4'b0000, mon_r}) &&
    (py_r == `RTCS_KEEP || py_r == {1'b0, yr_r}) &&
    (ph_r == `RTCS_KEEP || ph_r == {3'b000, hr_r}) &&
    (pn_r == `RTCS_KEEP || pn_r == {2'b00, min_r}) &&
    (ps_r == `RTCS_KEEP || ps_r == {2'b00, sec_r});

  // refresh classes: RUN writes time and hours, STOP writes time once on entry and then only with bit 4, never hours
  wire t_new = (ref_exp && !power_off && (run_mode || stat_r[`RTCS_ST_STOP_UPD])) ||
    run_fall;
  wire h_new = ref_exp && !power_off && run_mode;
  wire c_new = stat_r[`RTCS_ST_CAPTURE] && (run_fall || (pwr_rise &&
    (run_mode || stat_r[`RTCS_ST_STOP_UPD])));
  wire w_new = t_new | h_new | c_new;
  wire wr_end = wr_act_r && !apb_mwr && wr_idx_r == `RTCS_W_LAST;
  wire wr_en = (wr_idx_r <= `RTCS_W_TIME_LAST && upd_t_r) ||
    (wr_idx_r >= `RTCS_W_OH_FIRST && wr_idx_r <= `RTCS_W_OH_LAST && upd_h_r) ||
    (wr_idx_r >= `RTCS_W_SNAP && upd_c_r);

  always @* begin
    case (wr_idx_r)
      5'd0: wr_val = tw0;
      5'd1: wr_val = tw1;
      5'd2: wr_val = tw2;
      5'd3: wr_val = tw3;
      5'd12: wr_val = {8'h00, n2b({1'b0, oh_sec_r})};
      5'd13: wr_val = {n2b({1'b0, oh_min_r}), oh_h0_r};
      5'd14: wr_val = {oh_h1_r, oh_h2_r};
      5'd18: wr_val = snap_r[63:48];
      5'd19: wr_val = snap_r[47:32];
      5'd20: wr_val = snap_r[31:16];
      5'd21: wr_val = snap_r[15:0];
      default: wr_val = 16'h0000;
    endcase
  end

  rtcs_mem u_mem (
    .clk(pclk),
    .we(apb_mwr || (wr_act_r && wr_en)),
    .wa(apb_mwr ? dix[4:0] : wr_idx_r),
    .wd(apb_mwr ? pwdata[15:0] : wr_val),
    .ra(m_ra),
    .rd(mem_q)
  );

  always @* begin
    rd_val = 16'h0000;
    if (in_data)
      rd_val = mem_q;
    else if (hit_ad)
      rd_val = desc0_r;
    else if (hit_as)
      rd_val = desc1_r;
    else if (hit_sl)
      rd_val = desc2_r;
    else if (hit_hw)
      rd_val = {corr_bad, 13'h0000, fault_r};
    else if (hit_co)
      rd_val = corr_r;
    else if (hit_st)
      rd_val = stat_r;
  end

  // one wait state so that read data leave a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      if (!pwrite)
        prdata <= {16'h0000, rd_val};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always @* begin
    stat_nxt = stat_r;
    if (sw_st)
      stat_nxt = (stat_r & ~`RTCS_ST_SW_MASK) | (pwdata[15:0] & `RTCS_ST_SW_MASK);
    if (ev_done && kind_r == K_CLK) begin
      stat_nxt[`RTCS_ST_CLK_REQ] = sw_st && pwdata[`RTCS_ST_CLK_REQ];
      stat_nxt[`RTCS_ST_CLK_ERR] = !time_ok;
    end
    if (ev_done && kind_r == K_OH) begin
      stat_nxt[`RTCS_ST_OH_REQ] = sw_st && pwdata[`RTCS_ST_OH_REQ];
      stat_nxt[`RTCS_ST_OH_ERR] = !oh_ok;
    end
    if (ev_done && kind_r == K_PR) begin
      stat_nxt[`RTCS_ST_PR_REQ] = sw_st && pwdata[`RTCS_ST_PR_REQ];
      stat_nxt[`RTCS_ST_PR_ERR] = !time_ok;
      if (time_ok)
        stat_nxt[`RTCS_ST_PR_HIT] = 1'b0;
    end
    if (tick_d_r && pr_match)
      stat_nxt[`RTCS_ST_PR_HIT] = 1'b1;
    stat_nxt[`RTCS_ST_READABLE] = fault_r == 2'b00 &&
      !(st_r != S_IDLE && kind_r == K_CLK);
    if (cold)
      stat_nxt[`RTCS_ST_MODE12] = 1'b0;
    stat_nxt = stat_nxt & ~`RTCS_ST_RSVD;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= `RTCS_ST_RESET;
      desc0_r <= `RTCS_DESC_RESET;
      desc1_r <= `RTCS_DESC_RESET;
      desc2_r <= `RTCS_DESC_RESET;
      corr_r <= `RTCS_CORR_RESET;
      fault_r <= 2'b00;
      prompt_hit <= 1'b0;
      clock_readable <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      fault_r <= chip_fault;
      prompt_hit <= stat_r[`RTCS_ST_PR_HIT];
      clock_readable <= stat_r[`RTCS_ST_READABLE];
      if (apb_wr && hit_ad)
        desc0_r <= pwdata[15:0];
      if (apb_wr && hit_as)
        desc1_r <= pwdata[15:0];
      if (apb_wr && hit_sl)
        desc2_r <= pwdata[15:0];
      if (apb_wr && hit_co)
        corr_r <= pwdata[15:0];
    end
  end

  // settings fetch: four words per transfer, bus reads take precedence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      kind_r <= K_CLK;
      iss_r <= 3'd0;
      cap_r <= 3'd0;
      pend_r <= 1'b0;
    end else begin
      pend_r <= seq_go;
      case (st_r)
        S_IDLE: begin
          if (xfer_ok && any_req) begin
            st_r <= S_READ;
            iss_r <= 3'd0;
            cap_r <= 3'd0;
            kind_r <= stat_r[`RTCS_ST_CLK_REQ] ? K_CLK :
              stat_r[`RTCS_ST_OH_REQ] ? K_OH : K_PR;
          end
        end
        S_READ: begin
          if (seq_go)
            iss_r <= iss_r + 3'd1;
          if (pend_r) begin
            cap_r <= cap_r + 3'd1;
            if (cap_r == 3'd3)
              st_r <= S_EVAL;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  always @(posedge pclk) begin
    if (st_r == S_READ && pend_r)
      sbuf_r[cap_r[1:0]] <= mem_q;
  end

  // the clock ticks regardless of mode and power state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 32'h00000000;
      tick_d_r <= 1'b0;
      sec_r <= `RTCS_INIT_SEC;
      min_r <= `RTCS_INIT_MIN;
      hr_r <= `RTCS_INIT_HOUR;
      day_r <= `RTCS_INIT_DAY;
      mon_r <= `RTCS_INIT_MONTH;
      yr_r <= `RTCS_INIT_YEAR;
      wd_r <= `RTCS_INIT_WDAY;
    end else begin
      pre_cnt_r <= tick ? 32'h00000000 : pre_cnt_r + 32'h00000001;
      tick_d_r <= tick;
      if (tick) begin
        if (sec_r != 6'd59)
          sec_r <= sec_r + 6'd1;
        else begin
          sec_r <= 6'd0;
          if (min_r != 6'd59)
            min_r <= min_r + 6'd1;
          else begin
            min_r <= 6'd0;
            if (hr_r != 5'd23)
              hr_r <= hr_r + 5'd1;
            else begin
              hr_r <= 5'd0;
              wd_r <= (wd_r == 3'd7) ? 3'd1 : wd_r + 3'd1;
              if (day_r != mdays(mon_r, yr_r))
                day_r <= day_r + 5'd1;
              else begin
                day_r <= 5'd1;
                if (mon_r != 4'd12)
                  mon_r <= mon_r + 4'd1;
                else begin
                  mon_r <= 4'd1;
                  yr_r <= (yr_r == 7'd99) ? 7'd0 : yr_r + 7'd1;
                end
              end
            end
          end
        end
      end
      if (set_clk) begin
        if (bw != `RTCS_KEEP) wd_r <= bw[2:0];
        if (bd != `RTCS_KEEP) day_r <= nd[4:0];
        if (bm != `RTCS_KEEP) mon_r <= bm[7:4] != 4'd0 ? 4'd10 + bm[3:0] : bm[3:0];
        if (by != `RTCS_KEEP) yr_r <= b2n(by);
        if (bh != `RTCS_KEEP) hr_r <= hr24(bh, mode12);
        if (bn != `RTCS_KEEP) min_r <= nn[5:0];
        if (bs != `RTCS_KEEP) sec_r <= ns[5:0];
      end
      if (cold) begin
        sec_r <= `RTCS_INIT_SEC;
        min_r <= `RTCS_INIT_MIN;
        hr_r <= `RTCS_INIT_HOUR;
        day_r <= `RTCS_INIT_DAY;
        mon_r <= `RTCS_INIT_MONTH;
        yr_r <= `RTCS_INIT_YEAR;
        wd_r <= `RTCS_INIT_WDAY;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oh_sec_r <= 6'd0;
      oh_min_r <= 6'd0;
      oh_h0_r <= 8'h00;
      oh_h1_r <= 8'h00;
      oh_h2_r <= 8'h00;
      pr_arm_r <= 1'b0;
      {pw_r, pd_r, pm_r, py_r, ph_r, pn_r, ps_r} <= {7{`RTCS_KEEP}};
    end else begin
      if (tick && stat_r[`RTCS_ST_OH_EN] && !power_off) begin
        oh_sec_r <= (oh_sec_r == 6'd59) ? 6'd0 : oh_sec_r + 6'd1;
        if (oh_sec_r == 6'd59) begin
          oh_min_r <= (oh_min_r == 6'd59) ? 6'd0 : oh_min_r + 6'd1;
          if (oh_min_r == 6'd59) begin
            oh_h0_r <= bcd_inc(oh_h0_r);
            if (oh_h0_r == 8'h99) begin
              oh_h1_r <= bcd_inc(oh_h1_r);
              if (oh_h1_r == 8'h99)
                oh_h2_r <= bcd_inc(oh_h2_r);
            end
          end
        end
      end
      if (set_oh) begin
        if (bw != `RTCS_KEEP) oh_sec_r <= nw[5:0];
        if (bd != `RTCS_KEEP) oh_min_r <= nd[5:0];
        if (bm != `RTCS_KEEP) oh_h0_r <= bm;
        if (by != `RTCS_KEEP) oh_h1_r <= by;
        if (bh != `RTCS_KEEP) oh_h2_r <= bh;
      end
      if (set_pr) begin
        pr_arm_r <= 1'b1;
        pw_r <= bw;
        pd_r <= (bd == `RTCS_KEEP) ? bd : {1'b0, b2n(bd)};
        pm_r <= (bm == `RTCS_KEEP) ? bm : {1'b0, b2n(bm)};
        py_r <= (by == `RTCS_KEEP) ? by : {1'b0, b2n(by)};
        ph_r <= (bh == `RTCS_KEEP) ? bh : {3'b000, hr24(bh, mode12)};
        pn_r <= (bn == `RTCS_KEEP) ? bn : {1'b0, b2n(bn)};
        ps_r <= (bs == `RTCS_KEEP) ? bs : {1'b0, b2n(bs)};
      end
    end
  end

  // data-area writer walks all words once per trigger
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_r <= 32'h00000000;
      run_d_r <= 1'b0;
      pwr_d_r <= 1'b0;
      snap_r <= 64'h0000000000000000;
      wr_act_r <= 1'b0;
      wr_idx_r <= 5'd0;
      upd_t_r <= 1'b0;
      upd_h_r <= 1'b0;
      upd_c_r <= 1'b0;
    end else begin
      ref_cnt_r <= (cycle_start || ref_exp) ? 32'h00000000 : ref_cnt_r + 32'h00000001;
      run_d_r <= run_mode;
      pwr_d_r <= power_off;
      if (c_new)
        snap_r <= {tw0, tw1, tw2, tw3};
      upd_t_r <= (upd_t_r && !wr_end) || t_new;
      upd_h_r <= (upd_h_r && !wr_end) || h_new;
      upd_c_r <= (upd_c_r && !wr_end) || c_new;
      wr_act_r <= (wr_act_r && !wr_end) || w_new;
      // restart on any trigger so a stop mid-walk still rewrites words 0-3
      if (w_new)
        wr_idx_r <= 5'd0;
      else if (wr_act_r && !apb_mwr && !wr_end)
        wr_idx_r <= wr_idx_r + 5'd1;
    end
  end
endmodule // rtcs_top
`default_nettype wire

// file: tb/rtcs_props.sv
// port-level assertions for the clock status block
`timescale 1ns/1ns
`default_nettype none
`include "rtcs_defs.vh"
module rtcs_props (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [19:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [1:0] chip_fault, // chip defect flags
  input wire logic prompt_hit, // prompt reached
  input wire logic clock_readable // readable flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // status word read completing in this cycle
  wire st_rd = pready && !pwrite && paddr == 20'h3a868;
  wire hw_rd = pready && !pwrite && paddr == 20'h3a858;
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_READY_TIME: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_UNMAPPED: assert property (pready && paddr[19:18] != 2'h0 |-> pslverr)
    else $error("unmapped access not refused");
  AST_RSVD_ZERO: assert property (st_rd |-> (prdata[15:0] & `RTCS_ST_RSVD) == 16'h0000)
    else $error("reserved status bits not zero");
  AST_READABLE_PIN: assert property (st_rd |-> prdata[3] == clock_readable)
    else $error("readable pin differs from status");
  AST_PROMPT_PIN: assert property (st_rd |-> prdata[13] == prompt_hit)
    else $error("prompt pin differs from status");
  AST_HW_FAULT: assert property (hw_rd |-> prdata[1:0] == $past(chip_fault, 2))
    else $error("hardware status not chip fault");
  AST_FAULT_UNREAD: assert property ((chip_fault != 2'h0) [*4] |-> !clock_readable)
    else $error("clock readable while chip defective");
endmodule // rtcs_props
bind rtcs_top rtcs_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .chip_fault, .prompt_hit, .clock_readable);
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the clock status block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam integer SEC = 500;
  localparam logic [19:0] ST = 20'h3a868;
  localparam logic [19:0] HW = 20'h3a858;
  localparam logic [19:0] CR = 20'h3a860;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic run_mode = 1, power_off = 0, battery_ok = 1, cycle_start = 0, er;
  logic [1:0] chip_fault = 0;
  logic [19:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [15:0] rv;
  wire [31:0] prdata;
  wire pready, pslverr, prompt_hit, clock_readable;
  integer err_total = 0, compares = 0, cyc = 0;
  rtcs_top #(.SEC_CYCLES(SEC)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .run_mode, .power_off, .battery_ok,
    .chip_fault, .cycle_start, .prompt_hit, .clock_readable);
  initial forever #25 pclk = ~pclk;
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, run needs about 6000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // entered and left just after a rising edge; idle cycle keeps strobes single-driven
  task automatic apb(input logic w, input logic [19:0] a, input logic [15:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk);
    while (pready !== 1'h1);
    rv = prdata[15:0];
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  function automatic logic [19:0] dw(input logic [4:0] n);
    return 20'h3a880 + {13'h0000, n, 2'h0};
  endfunction
  task automatic rdk(input string nm, input logic [19:0] a, input logic [15:0] m,
    input logic [15:0] e);
    apb(1'h0, a, 16'h0000);
    chk(nm, rv & m, e);
  endtask
  task automatic wclr(input integer b);
    do apb(1'h0, ST, 16'h0000);
    while (rv[b] !== 1'h0);
  endtask
  task automatic xfer(input logic [4:0] w, input logic [63:0] v, input logic [15:0] q,
    input integer b);
    for (int i = 0; i < 4; i++)
      apb(1'h1, dw(w + 5'(i)), v[63 - 16 * i -: 16]);
    apb(1'h1, ST, q);
    wclr(b);
  endtask
  task automatic tick;
    cycle_start <= 1'h1;
    @(posedge pclk);
    cycle_start <= 1'h0;
    repeat (SEC + 40) @(posedge pclk);
  endtask
  task automatic t_reg;
    rdk("status", ST, 16'hffff, 16'h0008);
    rdk("hw", HW, 16'hffff, 16'h0000);
    rdk("corr", CR, 16'hffff, 16'h0000);
    apb(1'h1, ST, 16'hbbfb);
    rdk("mask", ST, 16'hffff, 16'h023a);
    apb(1'h1, 20'h40000, 16'h0000);
    chk("slverr", {15'h0000, er}, 16'h0001);
    apb(1'h1, HW, 16'hffff);
    rdk("hwro", HW, 16'hffff, 16'h0000);
    apb(1'h1, 20'h3a840, 16'h444b);
    rdk("desc", 20'h3a840, 16'hffff, 16'h444b);
    apb(1'h1, 20'h3a850, 16'h4612);
    rdk("sloc", 20'h3a850, 16'hffff, 16'h4612);
    apb(1'h1, ST, 16'h0000);
    $display("test reg done");
  endtask
  task automatic t_clock;
    xfer(5'h04, 64'h0002_0212_9210_3000, 16'h0004, 2);
    rdk("clkok", ST, 16'h0005, 16'h0000);
    tick;
    rdk("w1", dw(5'h01), 16'hffff, 16'h0212);
    rdk("w2", dw(5'h02), 16'hffff, 16'h9210);
    rdk("w3", dw(5'h03), 16'hff00, 16'h3000);
    xfer(5'h04, 64'hffff_ffff_ff08_ffff, 16'h0004, 2);
    tick;
    rdk("keep", dw(5'h02), 16'hffff, 16'h9208);
    xfer(5'h04, 64'hffff_ffff_ffff_6000, 16'h0004, 2);
    rdk("bad", ST, 16'h0005, 16'h0001);
    tick;
    rdk("old", dw(5'h02), 16'hffff, 16'h9208);
    xfer(5'h04, 64'hffff_ffff_ff81_ffff, 16'h0006, 2);
    tick;
    rdk("pm", dw(5'h02), 16'hffff, 16'h9281);
    $display("test clock done");
  endtask
  task automatic t_stop;
    logic [15:0] s;
    apb(1'h1, ST, 16'h0020);
    run_mode <= 1'h0;
    repeat (40) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, dw(5'(i)), 16'h0000);
      s = rv;
      rdk("snap", dw(5'(i + 18)), 16'hffff, s);
    end
    apb(1'h1, dw(5'h00), 16'h1234);
    tick;
    rdk("frozen", dw(5'h00), 16'hffff, 16'h1234);
    apb(1'h1, ST, 16'h0024);
    repeat (30) @(posedge pclk);
    rdk("noxfer", ST, 16'h0004, 16'h0004);
    apb(1'h1, ST, 16'h0010);
    tick;
    rdk("stopupd", dw(5'h00), 16'hffff, 16'h0002);
    apb(1'h1, ST, 16'h0000);
    run_mode <= 1'h1;
    apb(1'h1, dw(5'h12), 16'h5555);
    run_mode <= 1'h0;
    repeat (40) @(posedge pclk);
    rdk("unused", dw(5'h12), 16'hffff, 16'h5555);
    run_mode <= 1'h1;
    $display("test stop done");
  endtask
  task automatic pcyc(input logic bat);
    battery_ok <= bat;
    power_off <= 1'h1;
    repeat (20) @(posedge pclk);
    power_off <= 1'h0;
    tick;
  endtask
  task automatic t_power;
    pcyc(1'h1);
    rdk("kept", dw(5'h01), 16'hffff, 16'h0212);
    pcyc(1'h0);
    rdk("init0", dw(5'h00), 16'hffff, 16'h0004);
    rdk("init1", dw(5'h01), 16'hffff, 16'h0104);
    rdk("init2", dw(5'h02), 16'hffff, 16'h9212);
    $display("test power done");
  endtask
  task automatic t_corr;
    logic [15:0] v [4] = '{16'h0191, 16'h0190, 16'hfe6f, 16'hfe70};
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, CR, v[i]);
      rdk("corr", CR, 16'hffff, v[i]);
      rdk("corrbad", HW, 16'h8000, i[0] ? 16'h0000 : 16'h8000);
    end
    apb(1'h1, CR, 16'h0000);
    $display("test corr done");
  endtask
  task automatic t_fault;
    for (int f = 1; f < 4; f++) begin
      chip_fault <= 2'(f);
      repeat (8) @(posedge pclk);
      rdk("hwf", HW, 16'h0003, 16'(f));
      rdk("unread", ST, 16'h0008, 16'h0000);
      chk("rdpin", {15'h0000, clock_readable}, 16'h0000);
    end
    chip_fault <= 2'h0;
    repeat (8) @(posedge pclk);
    rdk("hwok", HW, 16'h0003, 16'h0000);
    rdk("read", ST, 16'h0008, 16'h0008);
    $display("test fault done");
  endtask
  task automatic t_prompt;
    xfer(5'h08, 64'hffff_ffff_ffff_ffff, 16'h4000, 14);
    repeat (2 * SEC + 40) @(posedge pclk);
    chk("hitpin", {15'h0000, prompt_hit}, 16'h0001);
    rdk("hit", ST, 16'h3000, 16'h2000);
    xfer(5'h08, 64'hffff_ffff_ffff_6000, 16'h4000, 14);
    rdk("prerr", ST, 16'h1000, 16'h1000);
    xfer(5'h0f, 64'h0000_0000_0000_ffff, 16'h0600, 10);
    rdk("ohok", ST, 16'h0100, 16'h0000);
    xfer(5'h0f, 64'h0060_0000_0000_ffff, 16'h0600, 10);
    rdk("oherr", ST, 16'h0100, 16'h0100);
    $display("test prompt done");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    t_reg;
    t_clock;
    t_stop;
    t_power;
    t_corr;
    t_fault;
    t_prompt;
    test_done;
  end
endmodule // testbench
`default_nettype wire
